// *** msr_cfg_pkg.sv ***
// Package with constants and carrier types for the special register and config port block.
package msr_cfg_pkg;
  localparam logic [31:0] SEL_CYCLE_COUNT = 32'h0000_0010;
  localparam logic [15:0] PORT_INDEX = 16'h0022;
  localparam logic [15:0] PORT_DATA = 16'h0023;
  localparam logic [7:0] IDX_LO_MIN = 8'hC0;
  localparam logic [7:0] IDX_LO_MAX = 8'hCF;
  localparam logic [7:0] IDX_HI_MIN = 8'hFE;
  localparam logic [7:0] IDX_HI_MAX = 8'hFF;
  localparam logic [15:0] DISP_LO = 16'h03B0;
  localparam logic [15:0] DISP_HI = 16'h03DF;
  localparam logic [63:0] CNT_RESET = 64'h0000_0000_0000_0000;
  localparam logic [63:0] CNT_ONE = 64'h0000_0000_0000_0001;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [1:0] PL_KERNEL = 2'h0;
  localparam int CR4_RESTRICT_BIT = 2;
  localparam int CFG_REGS = 18;
  localparam logic [4:0] HI_SLOT_BASE = 5'h10;

  // Instruction opcodes presented by the execution unit.
  typedef enum logic [1:0] {OP_NONE, OP_READ_MODEL, OP_WRITE_MODEL, OP_READ_COUNT} instr_op_t;

  // Instruction request from the execution unit.
  typedef struct packed {
    logic valid;
    instr_op_t op;
    logic [31:0] selector;
    logic [63:0] wdata;
    logic [1:0] priv;
    logic [31:0] cr4;
  } instr_req_t;

  // Instruction result back to the execution unit.
  typedef struct packed {
    logic done;
    logic gp_fault;
    logic [63:0] rdata;
  } instr_rsp_t;

  // I/O port request.
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [1:0] size;
    logic [31:0] wdata;
  } io_req_t;
endpackage

// *** msr_cfg_block.sv ***
// Model register path, cycle counter and configuration index/data port decode.
//
// Contract
// - Model read returns selected register into pair.
// - Model write stores pair into selected register.
// - Model read/write allowed only when privileged.
// - One 64-bit counter increments every core clock.
// - Counter runs on continuous clock through suspend.
// - Model read selector 10h returns counter.
// - Model write selector 10h loads counter.
// - Dedicated counter read returns counter, no selector.
// - Restrict flag clear: counter read at any level.
// - Restrict flag set: counter read level zero only.
// - 64 KB port space, 8/16/32-bit accesses.
// - Claimed config accesses make no external cycle.
// - Unarmed data access goes external, registers untouched.
// - Out-of-range index write goes external, no arming.
// - Index port reads always go external.
// - Enabled display range accesses trap to management interrupt.
// - Upper coprocessor range treated as ordinary I/O.
`timescale 1ns/1ns
module msr_cfg_block
  import msr_cfg_pkg::*;
(
  input wire logic core_clk, // Continuous core clock, 10 MHz.
  input wire logic reset, // Synchronous active high reset.
  input wire instr_req_t instr_req, // Instruction request, one-cycle valid.
  output instr_rsp_t instr_rsp, // Instruction result, registered.
  input wire io_req_t io_req, // I/O access request, one-cycle valid.
  input wire logic [2:0] io_trap_map_reg, // Display range trap enables.
  output logic io_ext_cycle, // Access forwarded to the external bus.
  output logic io_int_done, // Access completed on chip.
  output logic [7:0] io_rdata, // Data port read value, registered.
  output logic system_mgmt_interrupt, // Trap pulse for display range.
  output logic [63:0] cycle_counter // Current counter value.
);
  logic [63:0] cnt_ff;
  instr_rsp_t rsp_ff;
  logic armed_ff;
  logic [7:0] index_ff;
  logic [7:0] cfg_ff [CFG_REGS];
  logic [7:0] rdata_ff;
  logic ext_ff;
  logic int_ff;
  logic smi_ff;
  logic is_model;
  logic priv_ok;
  logic rd_ok;
  logic cnt_wr;
  logic idx_wr;
  logic idx_valid;
  logic data_hit;
  logic [4:0] slot;
  logic disp_hit;

  // Privilege checks for the instruction path.
  assign is_model = instr_req.valid &&
    (instr_req.op == OP_READ_MODEL || instr_req.op == OP_WRITE_MODEL);
  assign priv_ok = (instr_req.priv == PL_KERNEL);
  assign rd_ok = !instr_req.cr4[CR4_RESTRICT_BIT] || priv_ok;
  assign cnt_wr = is_model && priv_ok && instr_req.op == OP_WRITE_MODEL &&
    instr_req.selector == SEL_CYCLE_COUNT;

  // Counter: free running, loadable, wraps naturally, clears on reset.
  always_ff @(posedge core_clk)
  begin
    if (reset)
      cnt_ff <= CNT_RESET;
    else if (cnt_wr)
      cnt_ff <= instr_req.wdata;
    else
      cnt_ff <= cnt_ff + CNT_ONE;
  end
  assign cycle_counter = cnt_ff;

  // Instruction response with fault on privilege violation.
  always_ff @(posedge core_clk)
  begin
    if (reset)
      rsp_ff <= '0;
    else
    begin
      rsp_ff.done <= instr_req.valid && instr_req.op != OP_NONE;
      rsp_ff.gp_fault <= (is_model && !priv_ok) ||
        (instr_req.valid && instr_req.op == OP_READ_COUNT && !rd_ok);
      if (instr_req.valid && instr_req.op == OP_READ_COUNT && rd_ok)
        rsp_ff.rdata <= cnt_ff;
      else if (is_model && priv_ok && instr_req.op == OP_READ_MODEL)
        rsp_ff.rdata <= (instr_req.selector == SEL_CYCLE_COUNT) ? cnt_ff : CNT_RESET;
      else
        rsp_ff.rdata <= CNT_RESET;
    end
  end
  assign instr_rsp = rsp_ff;

  // Port decode over the 16-bit port space; upper range is plain I/O.
  assign idx_wr = io_req.valid && io_req.write && io_req.addr == PORT_INDEX;
  assign idx_valid = (io_req.wdata[7:0] >= IDX_LO_MIN && io_req.wdata[7:0] <= IDX_LO_MAX) ||
    (io_req.wdata[7:0] >= IDX_HI_MIN && io_req.wdata[7:0] <= IDX_HI_MAX);
  assign data_hit = io_req.valid && io_req.addr == PORT_DATA && armed_ff;
  assign slot = (index_ff >= IDX_HI_MIN) ? HI_SLOT_BASE + 5'(index_ff - IDX_HI_MIN)
    : 5'(index_ff - IDX_LO_MIN);
  assign disp_hit = io_req.valid && io_req.addr >= DISP_LO && io_req.addr <= DISP_HI &&
    |io_trap_map_reg;

  // Index arming: one data access per valid index write.
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      armed_ff <= 1'b0;
      index_ff <= BYTE_ZERO;
    end
    else if (idx_wr)
    begin
      armed_ff <= idx_valid;
      index_ff <= io_req.wdata[7:0];
    end
    else if (io_req.valid)
      armed_ff <= 1'b0;
  end

  // Configuration register storage, one entry per on-chip index.
  genvar gi;
  generate
    for (gi = 0; gi < CFG_REGS; gi++)
    begin : g_cfg
      always_ff @(posedge core_clk)
      begin
        if (reset)
          cfg_ff[gi] <= BYTE_ZERO;
        else if (data_hit && io_req.write && slot == 5'(gi))
          cfg_ff[gi] <= io_req.wdata[7:0];
      end
    end
  endgenerate

  // Access completion: on chip or external, plus display trap.
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ext_ff <= 1'b0;
      int_ff <= 1'b0;
      smi_ff <= 1'b0;
      rdata_ff <= BYTE_ZERO;
    end
    else
    begin
      int_ff <= data_hit || (idx_wr && idx_valid);
      ext_ff <= io_req.valid && !data_hit && !(idx_wr && idx_valid);
      smi_ff <= disp_hit;
      if (data_hit && !io_req.write)
        rdata_ff <= cfg_ff[slot];
    end
  end
  assign io_ext_cycle = ext_ff;
  assign io_int_done = int_ff;
  assign io_rdata = rdata_ff;
  assign system_mgmt_interrupt = smi_ff;

  // Checks.
  property p_cnt_inc;
    @(posedge core_clk) disable iff (reset) !$past(reset) && !$past(cnt_wr) |->
      cnt_ff == $past(cnt_ff) + CNT_ONE; // The edge leaving reset has no prior step.
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) else $error("Counter did not step.");
  property p_cnt_load;
    @(posedge core_clk) disable iff (reset) cnt_wr |=> cnt_ff == $past(instr_req.wdata);
  endproperty
  a_cnt_load: assert property (p_cnt_load) else $error("Counter load lost.");
  property p_model_fault;
    @(posedge core_clk) disable iff (reset) is_model && !priv_ok |=> instr_rsp.gp_fault;
  endproperty
  a_model_fault: assert property (p_model_fault) else $error("No fault for model op.");
  property p_rdc_restrict;
    @(posedge core_clk) disable iff (reset)
      instr_req.valid && instr_req.op == OP_READ_COUNT && instr_req.cr4[CR4_RESTRICT_BIT] &&
      instr_req.priv != PL_KERNEL |=> instr_rsp.gp_fault;
  endproperty
  a_rdc_restrict: assert property (p_rdc_restrict) else $error("Restricted read ran.");
  property p_rdc_free;
    @(posedge core_clk) disable iff (reset)
      instr_req.valid && instr_req.op == OP_READ_COUNT && !instr_req.cr4[CR4_RESTRICT_BIT]
      |=> !instr_rsp.gp_fault && instr_rsp.rdata == $past(cnt_ff);
  endproperty
  a_rdc_free: assert property (p_rdc_free) else $error("Free counter read wrong.");
  property p_rd_model;
    @(posedge core_clk) disable iff (reset)
      is_model && priv_ok && instr_req.op == OP_READ_MODEL &&
      instr_req.selector == SEL_CYCLE_COUNT |=> instr_rsp.rdata == $past(cnt_ff);
  endproperty
  a_rd_model: assert property (p_rd_model) else $error("Model read of counter wrong.");
  property p_idx_read_ext;
    @(posedge core_clk) disable iff (reset)
      io_req.valid && !io_req.write && io_req.addr == PORT_INDEX |=> io_ext_cycle && !io_int_done;
  endproperty
  a_idx_read_ext: assert property (p_idx_read_ext) else $error("Index read not external.");
  property p_bad_idx;
    @(posedge core_clk) disable iff (reset) idx_wr && !idx_valid |=> io_ext_cycle && !armed_ff;
  endproperty
  a_bad_idx: assert property (p_bad_idx) else $error("Bad index armed.");
  property p_unarmed;
    @(posedge core_clk) disable iff (reset)
      io_req.valid && io_req.addr == PORT_DATA && !armed_ff |=> io_ext_cycle && !io_int_done;
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("Unarmed data claimed.");
  property p_one_shot;
    @(posedge core_clk) disable iff (reset) data_hit |=> !armed_ff;
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("Index stayed armed.");
  property p_smi;
    @(posedge core_clk) disable iff (reset) disp_hit |=> system_mgmt_interrupt;
  endproperty
  a_smi: assert property (p_smi) else $error("Display trap missed.");

  // Reset clears the counter whatever it held before.
  property p_cnt_clear;
    @(posedge core_clk) reset |=> cnt_ff == CNT_RESET;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("Counter not cleared by reset.");

  // The all-ones value rolls over to zero rather than saturating.
  property p_cnt_wrap;
    @(posedge core_clk) disable iff (reset) (&cnt_ff) && !cnt_wr |=> cnt_ff == CNT_RESET;
  endproperty
  a_cnt_wrap: assert property (p_cnt_wrap) else $error("Counter did not wrap.");

  // A refused model write must leave the counter stepping as usual.
  property p_wr_refused;
    @(posedge core_clk) disable iff (reset)
      is_model && !priv_ok && instr_req.op == OP_WRITE_MODEL
      |=> cnt_ff == $past(cnt_ff) + CNT_ONE;
  endproperty
  a_wr_refused: assert property (p_wr_refused) else $error("Refused write hit counter.");

  // A write to any other selector is dropped and the counter keeps counting.
  property p_wr_other;
    @(posedge core_clk) disable iff (reset)
      is_model && instr_req.op == OP_WRITE_MODEL && instr_req.selector != SEL_CYCLE_COUNT
      |=> cnt_ff == $past(cnt_ff) + CNT_ONE;
  endproperty
  a_wr_other: assert property (p_wr_other) else $error("Other selector hit counter.");

  // A model read of any other selector returns an all-zero pair.
  property p_rd_other;
    @(posedge core_clk) disable iff (reset)
      is_model && priv_ok && instr_req.op == OP_READ_MODEL &&
      instr_req.selector != SEL_CYCLE_COUNT |=> instr_rsp.done && instr_rsp.rdata == CNT_RESET;
  endproperty
  a_rd_other: assert property (p_rd_other) else $error("Other selector read not zero.");

  // Level zero may use the counter read even with the restrict flag set.
  property p_rdc_kernel;
    @(posedge core_clk) disable iff (reset)
      instr_req.valid && instr_req.op == OP_READ_COUNT && priv_ok
      |=> !instr_rsp.gp_fault && instr_rsp.rdata == $past(cnt_ff);
  endproperty
  a_rdc_kernel: assert property (p_rdc_kernel) else $error("Level zero read wrong.");

  // A refused instruction hands back no data.
  property p_fault_no_data;
    @(posedge core_clk) disable iff (reset) instr_rsp.gp_fault |-> instr_rsp.rdata == CNT_RESET;
  endproperty
  a_fault_no_data: assert property (p_fault_no_data) else $error("Fault leaked data.");

  // Without a request the result stays quiet.
  property p_rsp_idle;
    @(posedge core_clk) disable iff (reset)
      !instr_req.valid |=> !instr_rsp.done && !instr_rsp.gp_fault && instr_rsp.rdata == CNT_RESET;
  endproperty
  a_rsp_idle: assert property (p_rsp_idle) else $error("Result without request.");

  // Every port access gets exactly one answer, on chip or outside.
  property p_one_answer;
    @(posedge core_clk) disable iff (reset) io_req.valid |=> io_ext_cycle != io_int_done;
  endproperty
  a_one_answer: assert property (p_one_answer) else $error("Access not answered once.");

  // No answer and no trap appear without an access.
  property p_no_stray;
    @(posedge core_clk) disable iff (reset)
      !io_req.valid |=> !io_ext_cycle && !io_int_done && !system_mgmt_interrupt;
  endproperty
  a_no_stray: assert property (p_no_stray) else $error("Answer without access.");

  // A claimed data access stays on chip.
  property p_claimed;
    @(posedge core_clk) disable iff (reset) data_hit |=> io_int_done && !io_ext_cycle;
  endproperty
  a_claimed: assert property (p_claimed) else $error("Claimed access went outside.");

  // A valid index write is answered on chip and arms the next data access.
  property p_idx_arm;
    @(posedge core_clk) disable iff (reset) idx_wr && idx_valid |=> io_int_done && armed_ff;
  endproperty
  a_idx_arm: assert property (p_idx_arm) else $error("Valid index not armed.");

  // Ports other than the index/data pair, upper range included, go outside.
  property p_plain_io;
    @(posedge core_clk) disable iff (reset)
      io_req.valid && io_req.addr != PORT_INDEX && io_req.addr != PORT_DATA |=> io_ext_cycle;
  endproperty
  a_plain_io: assert property (p_plain_io) else $error("Plain port not external.");

  // With every trap enable clear the display range raises nothing.
  property p_smi_off;
    @(posedge core_clk) disable iff (reset) io_trap_map_reg == 3'h0 |=> !system_mgmt_interrupt;
  endproperty
  a_smi_off: assert property (p_smi_off) else $error("Trap while disabled.");

  // Coverage of the main scenarios.
  c_cfg_write: cover property (@(posedge core_clk) idx_wr && idx_valid ##1 data_hit);
  c_cnt_load: cover property (@(posedge core_clk) cnt_wr);
  c_fault: cover property (@(posedge core_clk) instr_rsp.gp_fault);
  c_smi: cover property (@(posedge core_clk) system_mgmt_interrupt);
  c_wrap: cover property (@(posedge core_clk) (&cnt_ff));
endmodule

// *** ext_io_model.sv ***
// External I/O bus partner that counts forwarded cycles and trap pulses.
`timescale 1ns/1ns
module ext_io_model
(
  input wire logic core_clk, // Core clock.
  input wire logic reset, // Synchronous reset.
  input wire logic io_ext_cycle, // Forwarded access pulse.
  input wire logic system_mgmt_interrupt, // Trap pulse.
  output int ext_count, // Forwarded cycles seen.
  output int trap_count // Trap pulses seen.
);
  // Each pulse stands one cycle, so it is counted on that edge.
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ext_count <= 0;
      trap_count <= 0;
    end
    else
    begin
      ext_count <= ext_count + int'(io_ext_cycle);
      trap_count <= trap_count + int'(system_mgmt_interrupt);
    end
  end
endmodule

// *** testbench.sv ***
// Self-checking bench for the model register, counter and config port block.
`timescale 1ns/1ns
module testbench;
  import msr_cfg_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  instr_req_t instr_req = '0;
  instr_rsp_t instr_rsp;
  io_req_t io_req = '0;
  logic [2:0] io_trap_map_reg = 3'h0;
  logic io_ext_cycle, io_int_done, system_mgmt_interrupt, armed, gp;
  logic [7:0] io_rdata, idx, cur;
  logic [7:0] mem [256] = '{default: 8'h00};
  logic [63:0] cycle_counter, cnt0, exp;
  logic [31:0] r;
  logic [31:0] seed = 32'h0000_000D;
  int fails = 0;
  int n_compared = 0;
  int ext_count, trap_count;
  int n_ext = 0;
  int n_trap = 0;

  // Clock of 100 ns period.
  always #50 core_clk = ~core_clk;

  msr_cfg_block dut (.core_clk(core_clk), .reset(reset), .instr_req(instr_req),
    .instr_rsp(instr_rsp), .io_req(io_req), .io_trap_map_reg(io_trap_map_reg),
    .io_ext_cycle(io_ext_cycle), .io_int_done(io_int_done), .io_rdata(io_rdata),
    .system_mgmt_interrupt(system_mgmt_interrupt), .cycle_counter(cycle_counter));
  ext_io_model bus (.core_clk(core_clk), .reset(reset), .io_ext_cycle(io_ext_cycle),
    .system_mgmt_interrupt(system_mgmt_interrupt), .ext_count(ext_count),
    .trap_count(trap_count));

  // Xorshift generator, so every run sees the same stimulus.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // True for an index that the on-chip registers claim.
  function automatic logic in_cfg(logic [7:0] i);
    return (i >= IDX_LO_MIN && i <= IDX_LO_MAX) || i >= IDX_HI_MIN;
  endfunction

  // Expected {external, internal, trap} flags of one access.
  function automatic logic [2:0] io_exp(logic arm, logic wr, logic [15:0] a, logic [7:0] d);
    logic own;
    own = (wr && a == PORT_INDEX && in_cfg(d)) || (arm && a == PORT_DATA);
    return {!own, own, !own && io_trap_map_reg != 3'h0 && a >= DISP_LO && a <= DISP_HI};
  endfunction

  task automatic chk_data(logic [63:0] got, logic [63:0] want);
    n_compared++;
    if (got !== want)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  task automatic chk_flags(logic [2:0] got, logic [2:0] want);
    n_compared++;
    if (got !== want)
    begin
      fails++;
      $display("ERROR t=%0t flags got=%h exp=%h", $time, got, want);
    end
  endtask

  // One instruction; the answer stands after the next falling edge.
  task automatic instr(instr_op_t op, logic [31:0] sel, logic [63:0] wd, logic [1:0] pl,
    logic [31:0] cr4);
    @(negedge core_clk);
    instr_req = '{1'b1, op, sel, wd, pl, cr4};
    cnt0 = cycle_counter;
    @(negedge core_clk);
    instr_req.valid = 1'b0;
  endtask

  // Answer flags, and data: the counter when not refused, zero when refused.
  task automatic chk_rsp(logic fault);
    chk_flags({1'b0, instr_rsp.gp_fault, instr_rsp.done}, {2'(fault), 1'b1});
    if (!fault)
      chk_data(instr_rsp.rdata, cnt0);
    else
      chk_data(instr_rsp.rdata, CNT_RESET);
  endtask

  // One port access, checked against the bench's own arming and storage.
  task automatic io(logic wr, logic [15:0] a, logic [7:0] d);
    logic [2:0] want;
    logic was;
    want = io_exp(armed, wr, a, d);
    was = armed && a == PORT_DATA;
    armed = wr && a == PORT_INDEX && in_cfg(d);
    if (armed)
      cur = d;
    n_ext += int'(want[2]);
    n_trap += int'(want[0]);
    @(negedge core_clk);
    io_req = '{1'b1, wr, a, 2'(rnd() % 3), {24'h00_0000, d}};
    @(negedge core_clk);
    io_req.valid = 1'b0;
    chk_flags({io_ext_cycle, io_int_done, system_mgmt_interrupt}, want);
    if (was && wr)
      mem[cur] = d;
    if (was && !wr)
      chk_data(64'(io_rdata), 64'(mem[cur]));
  endtask

  task automatic finish_test();
    $display("TB: compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles that the tests take.
  initial
  begin
    #(5000 * 100);
    fails++;
    finish_test();
  end

  // Reset, counter and model register tests, then the config port tests.
  initial
  begin
    armed = 1'b0;
    repeat (3) @(negedge core_clk);
    chk_data(cycle_counter, CNT_RESET);
    reset = 1'b0;
    @(negedge core_clk);
    chk_data(cycle_counter, CNT_ONE);
    for (int i = 0; i < 8; i++)
    begin
      r = rnd();
      exp = (i == 0) ? 64'hFFFF_FFFF_FFFF_FFFF : {rnd(), r};
      instr(OP_WRITE_MODEL, SEL_CYCLE_COUNT, exp, PL_KERNEL, 32'h0);
      chk_data(cycle_counter, exp);
      @(negedge core_clk);
      chk_data(cycle_counter, exp + CNT_ONE);
      instr(OP_READ_COUNT, r, 64'h0, r[1:0], {29'h0, r[2], 2'h0});
      chk_rsp(r[2] && r[1:0] != PL_KERNEL);
      gp = r[4:3] != PL_KERNEL;
      instr(OP_READ_MODEL, SEL_CYCLE_COUNT, 64'h0, r[4:3], 32'h0);
      chk_rsp(gp);
      instr(OP_WRITE_MODEL, SEL_CYCLE_COUNT, {r, r}, r[6:5] | 2'h1, 32'h0);
      chk_data(cycle_counter, cnt0 + CNT_ONE);
      instr(OP_WRITE_MODEL, {r[31:8], 8'h0F}, {r, r}, PL_KERNEL, 32'h0);
      chk_data(cycle_counter, cnt0 + CNT_ONE);
      instr(OP_READ_MODEL, {r[31:8], 8'h0F}, 64'h0, PL_KERNEL, 32'h0);
      chk_data(instr_rsp.rdata, CNT_RESET);
    end
    $display("TEST counter done");
    // Mid-run reset with the index armed: counter restarts, arming is lost.
    io(1'b1, PORT_INDEX, IDX_LO_MIN);
    reset = 1'b1;
    armed = 1'b0;
    n_ext = 0;
    n_trap = 0;
    repeat (2) @(negedge core_clk);
    chk_data(cycle_counter, CNT_RESET);
    reset = 1'b0;
    @(negedge core_clk);
    chk_data(cycle_counter, CNT_ONE);
    io(1'b0, PORT_DATA, 8'h00);
    $display("TEST mid-run reset done");
    for (int i = 0; i < 12; i++)
    begin
      r = rnd();
      idx = (i % 2) ? r[7:0] : {4'hC, r[11:8]};
      io_trap_map_reg = r[26:24];
      io(1'b1, PORT_INDEX, idx);
      io(r[27], PORT_DATA, r[23:16]);
      io(1'b1, PORT_INDEX, idx);
      io(1'b0, PORT_DATA, 8'h00);
      io(r[28], PORT_DATA, r[23:16]);
      io(1'b0, PORT_INDEX, idx);
      io(r[29], DISP_LO + 16'(r[5:0]), r[15:8]);
      io(r[30], 16'(rnd() >> 16), r[15:8]);
    end
    // The partner counts the last pulse on the edge after it appears.
    @(negedge core_clk);
    chk_data(64'(ext_count), 64'(n_ext));
    chk_data(64'(trap_count), 64'(n_trap));
    $display("TEST config port done");
    finish_test();
  end
endmodule
